// File: rtl/fpg_pkg.sv
// Purpose: Constants and types for the flat panel geometry and attribute register bank
// Assumes: Indexed I/O access with index already decoded to 8 bits
// Notes:
// Contract
// - Row position is 10 bits: row offset low byte plus overflow bits 3:2.
// - Row position applies only while automatic centering is off.
// - Vertical size is low byte plus overflow bits 6:4; single scan: rows minus one.
// - Dual scan: vertical size means panel rows divided by two, minus one.
// - Overflow bit 1 is horizontal size bit 8; bit 0 is column offset bit 8.
// - Outside text-mode attribute emulation, auto gray mapping routes pixels through the gray palette, else bypasses it.
// - Text reverse video (bit 6) inverts panel video in text modes only.
// - Graphics reverse video (bit 5) inverts panel video in graphics modes only.
// - Extra line clock (bit 4) adds one line pulse on dual-scan lower half.
// - Attribute emulation (bit 3) picks contrast-optimized grays in text modes.
// - With emulation off, colors map freely through attribute palette and panel palette.
// - Bit 2 reports standby, read only; writes do not change it.
// - Compression bit 1 clear pans 640 of 720 pixels; 10 drops every ninth.
// - Compression 11 ORs ninth pixel into eighth pixel.
// - Horizontal size and column offset count four-pixel nibbles.
package fpg_pkg;
  localparam logic [7:0] ROW_OFS_IDX  = 8'hd2;
  localparam logic [7:0] VSIZE_IDX    = 8'hd3;
  localparam logic [7:0] OVF_IDX      = 8'hd4;
  localparam logic [7:0] ATTR_IDX     = 8'hd5;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [7:0] OVF_WR_MASK  = 8'h7f;
  localparam logic [7:0] ATTR_WR_MASK = 8'hfb;
  localparam int         STBY_BIT     = 2;
  localparam int         NIBBLE_SHIFT = 2;

  typedef struct packed {
    logic       auto_gray_mapping;
    logic       text_reverse;
    logic       gfx_reverse;
    logic       extra_line_clk;
    logic       attr_emulation;
    logic [1:0] compress_mode;
  } fpg_attr_t;

  typedef struct packed {
    logic [9:0]  row_pos;
    logic [10:0] vsize;
    logic [8:0]  hsize;
    logic [8:0]  col_ofs;
  } fpg_geom_t;
endpackage

// File: rtl/fpg_byte_reg.sv
// Purpose: One masked write register byte
// Assumes: Write strobe synchronous to sys_clk
// Notes: Bits outside the mask hold reset value
`timescale 1ns/1ps
module fpg_byte_reg (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_mask,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);
  logic [7:0] q_nxt;
  assign q_nxt = (wr_data & wr_mask) | (q & ~wr_mask);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= fpg_pkg::RESET_BYTE;
    end else if (ce && wr_en) begin
      q <= q_nxt;
    end
  end
endmodule

// File: rtl/fpg_pixel_ctl.sv
// Purpose: Per-pixel panel attribute path
// Assumes: One pixel per enabled cycle
// Notes: Output registered
`timescale 1ns/1ps
module fpg_pixel_ctl (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire fpg_pkg::fpg_attr_t attr,
  input  wire logic              text_mode,
  input  wire logic [5:0]        raw_gray,
  input  wire logic [5:0]        map_gray,
  input  wire logic [5:0]        emu_gray,
  output logic      [5:0]        gray_out
);
  logic [5:0] sel_gray;
  logic       invert;
  assign sel_gray = (text_mode && attr.attr_emulation) ? emu_gray :
                    (attr.auto_gray_mapping ? map_gray : raw_gray);
  assign invert   = text_mode ? attr.text_reverse : attr.gfx_reverse;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gray_out <= 6'h00;
    end else if (ce) begin
      gray_out <= invert ? ~sel_gray : sel_gray;
    end
  end
endmodule

// File: rtl/fpg_regs.sv
// Purpose: Flat panel geometry and attribute register bank on the indexed I/O port
// Assumes: Index and write data synchronous to sys_clk; reads return a registered byte
// Notes: Dual-scan lower half extra line pulse follows the lower-half start strobe
`timescale 1ns/1ps
module fpg_regs (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic [7:0]         idx,
  input  wire logic               wr_stb,
  input  wire logic               rd_stb,
  input  wire logic [7:0]         wr_data,
  input  wire logic               standby,
  input  wire logic               auto_center,
  input  wire logic               dual_scan,
  input  wire logic               lower_half_start,
  input  wire logic               text_mode,
  input  wire logic [5:0]         raw_gray,
  input  wire logic [5:0]         map_gray,
  input  wire logic [5:0]         emu_gray,
  input  wire logic               pix_ninth,
  input  wire logic               pix_eighth_on,
  input  wire logic               pix_ninth_on,
  output logic      [7:0]         rd_data,
  output fpg_pkg::fpg_geom_t      geom,
  output logic      [9:0]         row_pos_eff,
  output logic      [10:0]        panel_rows,
  output logic      [10:0]        hsize_pixels,
  output logic      [10:0]        col_ofs_pixels,
  output fpg_pkg::fpg_attr_t      attr,
  output logic                    extra_line_pulse,
  output logic                    pix_drop,
  output logic                    pix_eighth_out,
  output logic      [5:0]         gray_out
);
  logic [7:0] row_ofs_q;
  logic [7:0] vsize_q;
  logic [7:0] ovf_q;
  logic [7:0] attr_q;
  logic       standby_r;
  logic [7:0] rd_nxt;
  fpg_pkg::fpg_geom_t geom_nxt;
  fpg_pkg::fpg_attr_t attr_nxt;

  fpg_byte_reg u_row (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .wr_en(wr_stb && idx == fpg_pkg::ROW_OFS_IDX), .wr_mask(8'hff), .wr_data(wr_data), .q(row_ofs_q));
  fpg_byte_reg u_vsz (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .wr_en(wr_stb && idx == fpg_pkg::VSIZE_IDX), .wr_mask(8'hff), .wr_data(wr_data), .q(vsize_q));
  // Reserved bit 7 never stored
  fpg_byte_reg u_ovf (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .wr_en(wr_stb && idx == fpg_pkg::OVF_IDX), .wr_mask(fpg_pkg::OVF_WR_MASK), .wr_data(wr_data),
    .q(ovf_q));
  // Standby bit not writable
  fpg_byte_reg u_att (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .wr_en(wr_stb && idx == fpg_pkg::ATTR_IDX), .wr_mask(fpg_pkg::ATTR_WR_MASK), .wr_data(wr_data),
    .q(attr_q));

  assign geom_nxt.row_pos = {ovf_q[3:2], row_ofs_q};
  assign geom_nxt.vsize   = {ovf_q[6:4], vsize_q};
  assign geom_nxt.hsize   = {ovf_q[1], 8'h00};
  assign geom_nxt.col_ofs = {ovf_q[0], 8'h00};
  assign attr_nxt = '{auto_gray_mapping: attr_q[7], text_reverse: attr_q[6], gfx_reverse: attr_q[5],
                      extra_line_clk: attr_q[4], attr_emulation: attr_q[3], compress_mode: attr_q[1:0]};

  assign rd_nxt = (idx == fpg_pkg::ROW_OFS_IDX) ? row_ofs_q :
                  (idx == fpg_pkg::VSIZE_IDX)   ? vsize_q :
                  (idx == fpg_pkg::OVF_IDX)     ? (ovf_q & fpg_pkg::OVF_WR_MASK) :
                  (idx == fpg_pkg::ATTR_IDX)    ? {attr_q[7:3], standby_r, attr_q[1:0]} :
                  8'h00;

  function automatic logic [10:0] nib_to_pix(input logic [8:0] n);
    nib_to_pix = {n, 2'b00};
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_r <= 1'b0;
    end else if (ce) begin
      standby_r <= standby;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= fpg_pkg::RESET_BYTE;
    end else if (ce && rd_stb) begin
      rd_data <= rd_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      geom           <= '0;
      row_pos_eff    <= 10'h000;
      panel_rows     <= 11'h000;
      hsize_pixels   <= 11'h000;
      col_ofs_pixels <= 11'h000;
      attr           <= '0;
    end else if (ce) begin
      geom           <= geom_nxt;
      row_pos_eff    <= auto_center ? 10'h000 : geom_nxt.row_pos;
      panel_rows     <= dual_scan ? 11'((geom_nxt.vsize + 11'h001) << 1)
                                  : 11'(geom_nxt.vsize + 11'h001);
      hsize_pixels   <= nib_to_pix(geom_nxt.hsize);
      col_ofs_pixels <= nib_to_pix(geom_nxt.col_ofs);
      attr           <= attr_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      extra_line_pulse <= 1'b0;
      pix_drop         <= 1'b0;
      pix_eighth_out   <= 1'b0;
    end else if (ce) begin
      extra_line_pulse <= attr_q[4] && dual_scan && lower_half_start;
      pix_drop         <= pix_ninth && attr_q[1];
      pix_eighth_out   <= (attr_q[1:0] == 2'b11) ? (pix_eighth_on | pix_ninth_on) : pix_eighth_on;
    end
  end

  fpg_pixel_ctl u_pix (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .attr(attr_nxt), .text_mode(text_mode),
    .raw_gray(raw_gray), .map_gray(map_gray), .emu_gray(emu_gray), .gray_out(gray_out));

  localparam int STBY_BIT_L = fpg_pkg::STBY_BIT;

  sequence s_wr_ovf;
    ce && wr_stb && idx == fpg_pkg::OVF_IDX;
  endsequence

  chk_row_pos_form: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce |=> geom.row_pos == {$past(ovf_q[3:2]), $past(row_ofs_q)})
    else $error("row position mismatch");
  chk_autocenter_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && auto_center |=> row_pos_eff == 10'h000)
    else $error("row offset applied under autocenter");
  chk_vsize_form: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce |=> geom.vsize == {$past(ovf_q[6:4]), $past(vsize_q)})
    else $error("vertical size mismatch");
  chk_dual_rows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && dual_scan |=> panel_rows == 11'((geom.vsize + 11'h001) << 1))
    else $error("dual scan rows wrong");
  chk_ovf_bit7_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_wr_ovf ##1 (ce && rd_stb && idx == fpg_pkg::OVF_IDX) |=> rd_data[7] == 1'b0)
    else $error("overflow bit 7 not zero");
  chk_standby_ro: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && wr_stb && idx == fpg_pkg::ATTR_IDX |=> attr_q[STBY_BIT_L] == 1'b0)
    else $error("standby bit written");
  chk_extra_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && !attr_q[4] |=> !extra_line_pulse)
    else $error("extra line pulse while disabled");
  chk_or_ninth: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && attr_q[1:0] == 2'b11 && pix_ninth_on |=> pix_eighth_out)
    else $error("ninth pixel not merged");
  chk_nibble_units: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce |=> hsize_pixels[1:0] == 2'b00 && hsize_pixels[10:2] == $past(geom_nxt.hsize))
    else $error("hsize not in nibbles");
endmodule

// File: dv/fpg_host_model.sv
// Purpose: Host software model driving the indexed register port
// Assumes: Requests change just after a rising edge and hold for one strobe cycle
// Notes: Released write data shows the inverse of the last byte
`timescale 1ns/1ps
module fpg_host_model (
  input  wire logic       sys_clk,
  output logic      [7:0] idx,
  output logic            wr_stb,
  output logic            rd_stb,
  output logic      [7:0] wr_data
);
  initial begin
    idx     = 8'h00;
    wr_stb  = 1'b0;
    rd_stb  = 1'b0;
    wr_data = 8'h00;
  end
  // Write one byte; strobe stands for exactly one edge
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    idx     <= i;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge sys_clk);
    wr_stb  <= 1'b0;
    wr_data <= ~d;
  endtask
  // Read request; caller samples rd_data at the returned falling edge
  task automatic rd(input logic [7:0] i);
    @(posedge sys_clk);
    idx    <= i;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
endmodule

// File: dv/fpg_regs_bench.sv
// Purpose: Self-checking bench for the panel geometry and attribute register bank
// Assumes: Byte model of the four registers predicts every read and derived output, except pix_drop in compression mode 11
// Notes: Random bytes from a fixed seed
`timescale 1ns/1ps
module flat_panel_geometry_attr_regs_bench;
  logic sys_clk = 1'b0, rst_n = 1'b0, standby = 1'b0, auto_center = 1'b0, dual_scan = 1'b0;
  logic lower_half_start = 1'b0, text_mode = 1'b0, pix_ninth = 1'b0, pix_eighth_on = 1'b0, pix_ninth_on = 1'b0;
  logic [5:0] raw_gray = 6'h00, map_gray = 6'h00, emu_gray = 6'h00, gray_out, g;
  logic [7:0] idx, wr_data, rd_data, d, a;
  logic wr_stb, rd_stb, extra_line_pulse, pix_drop, pix_eighth_out;
  logic [9:0] row_pos_eff;
  logic [10:0] panel_rows, hsize_pixels, col_ofs_pixels, vs;
  fpg_pkg::fpg_geom_t geom;
  fpg_pkg::fpg_attr_t attr;
  logic [7:0] mdl [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  integer seed = 32'hc330, miscompares = 0, checks_done = 0, i, k;
  initial forever #2.5 sys_clk = ~sys_clk;
  fpg_host_model fpg_host_model_i (.sys_clk(sys_clk), .idx(idx), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data));
  fpg_regs fpg_regs_i (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .idx(idx), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wr_data(wr_data), .standby(standby), .auto_center(auto_center), .dual_scan(dual_scan),
    .lower_half_start(lower_half_start), .text_mode(text_mode), .raw_gray(raw_gray), .map_gray(map_gray),
    .emu_gray(emu_gray), .pix_ninth(pix_ninth), .pix_eighth_on(pix_eighth_on), .pix_ninth_on(pix_ninth_on),
    .rd_data(rd_data), .geom(geom), .row_pos_eff(row_pos_eff), .panel_rows(panel_rows),
    .hsize_pixels(hsize_pixels), .col_ofs_pixels(col_ofs_pixels), .attr(attr),
    .extra_line_pulse(extra_line_pulse), .pix_drop(pix_drop), .pix_eighth_out(pix_eighth_out), .gray_out(gray_out));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Write through the host and mirror it in the byte model
  task automatic put(input int n, input logic [7:0] v);
    fpg_host_model_i.wr(8'hd2 + 8'(n), v);
    mdl[n] = v & (n == 2 ? 8'h7f : n == 3 ? 8'hfb : 8'hff);
  endtask
  // Read every register and the geometry derived from them
  task automatic sweep;
    for (k = 0; k < 4; k++) begin
      fpg_host_model_i.rd(8'hd2 + 8'(k));
      check("rd_data", rd_data, k == 3 ? mdl[3] | {5'h00, standby, 2'h0} : mdl[k]);
    end
    vs = {mdl[2][6:4], mdl[1]};
    check("row_pos", geom.row_pos, {mdl[2][3:2], mdl[0]});
    check("row_pos_eff", row_pos_eff, auto_center ? 10'h000 : {mdl[2][3:2], mdl[0]});
    check("vsize", geom.vsize, vs);
    check("panel_rows", panel_rows, dual_scan ? 11'((vs + 11'h001) * 2) : 11'(vs + 11'h001));
    check("hsize_col_ofs_msb", {geom.hsize[8], geom.col_ofs[8]}, mdl[2][1:0]);
    check("hsize_pixels", hsize_pixels, {mdl[2][1], 10'h000});
    check("col_ofs_pixels", col_ofs_pixels, {mdl[2][0], 10'h000});
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    sweep();
    put(2, 8'hff);
    put(3, 8'h04);
    sweep();
    fpg_host_model_i.wr(8'h10, 8'h5a);
    fpg_host_model_i.rd(8'h10);
    check("unmapped", rd_data, 8'h00);
    for (i = 0; i < 12; i++) begin
      standby <= $random(seed);
      auto_center <= $random(seed);
      dual_scan <= $random(seed);
      put(i % 3, 8'($random(seed)));
      sweep();
    end
    for (i = 0; i < 24; i++) begin
      a = 8'($random(seed));
      put(3, a);
      @(posedge sys_clk);
      {text_mode, pix_ninth, pix_eighth_on, pix_ninth_on, dual_scan} <= 5'($random(seed));
      {raw_gray, map_gray, emu_gray} <= 18'($random(seed));
      lower_half_start <= 1'b1;
      @(posedge sys_clk);
      lower_half_start <= 1'b0;
      @(negedge sys_clk);
      check("extra_line_pulse", extra_line_pulse, a[4] & dual_scan);
      check("attr", attr, {a[7:3], a[1:0]});
      g = a[7] ? map_gray : raw_gray;
      if (text_mode && a[3]) g = emu_gray;
      if (text_mode ? a[6] : a[5]) g = ~g;
      check("gray_out", gray_out, g);
      if (a[1:0] != 2'b11) check("pix_drop", pix_drop, a[1] & pix_ninth);
      check("pix_eighth_out", pix_eighth_out, pix_eighth_on | (a[1:0] == 2'b11 && pix_ninth_on));
    end
    results();
  end
endmodule
